/* File: design/psrs_pkg.sv */
// Purpose: Shared constants and types for the PHY state and register space block.
// Assumes: 8-bit address and data on the serial management line.
// Notes: The interface clock is ref_clk_i divided by four.
package psrs_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int DYN_AW = 5;
  localparam int DYN_DEPTH = 32;
  localparam logic [7:0] DYN_LAST = 8'h1f;
  localparam logic [7:0] STATIC_LAST = 8'h7f;
  localparam logic [7:0] ADDR_STATE_REQ = 8'h00;
  localparam logic [7:0] ADDR_STATE_STAT = 8'h01;
  localparam logic [7:0] ADDR_REGDOM_0 = 8'h20;
  localparam logic [7:0] ADDR_REGDOM_1 = 8'h21;
  localparam logic [7:0] ADDR_RATE_0 = 8'h22;
  localparam logic [7:0] ADDR_RATE_1 = 8'h23;
  localparam logic [7:0] ADDR_CHAN = 8'h24;
  localparam logic [2:0] REGDOM_RSVD = 3'h0;
  localparam logic [7:0] REGDOM_HI_RSVD = 8'h00;
  localparam logic [15:0] RATE_VALID_MASK = 16'h03ed;
  localparam logic [7:0] READ_ZERO = 8'h00;
  localparam logic [2:0] CODE_RESET = 3'h0;
  localparam logic [2:0] CODE_SLEEP = 3'h1;
  localparam logic [2:0] CODE_STANDBY = 3'h2;
  localparam logic [2:0] CODE_READY = 3'h3;
  localparam logic [2:0] CODE_TX = 3'h4;
  localparam logic [2:0] CODE_RX = 3'h5;
  localparam logic [3:0] STAT_RSVD = 4'h0;
  localparam logic [1:0] PH_RISE = 2'h0;
  localparam logic [1:0] PH_FALL = 2'h2;
  localparam logic [1:0] PH_SAMPLE = 2'h3;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam int SYNC_STOP = 0;
  localparam int SYNC_WAKE = 1;
  localparam int SYNC_SD = 2;

  typedef enum logic [2:0] {PS_RESET, PS_SLEEP, PS_STANDBY, PS_READY, PS_TX, PS_RX}
    psrs_state_type;
  typedef enum logic [2:0] {SM_IDLE, SM_RW, SM_ADDR, SM_WDATA, SM_TURN, SM_RDATA}
    psrs_ser_type;
  typedef enum logic [1:0] {RG_DYN, RG_STATIC, RG_VENDOR} psrs_region_type;
  typedef struct packed {
    logic en;
    logic [DYN_AW-1:0] addr;
    logic [DATA_W-1:0] data;
  } psrs_wr_type;
  typedef struct packed {
    logic rise;
    logic sample;
  } psrs_tick_type;
endpackage

/* File: design/psrs_dyn_mem.sv */
// Purpose: Dynamic register storage, 32 bytes, registered read.
// Assumes: One write and one read port, both on the block clock.
// Notes: All bytes clear to zero on reset.
`timescale 1ns/1ps
module psrs_dyn_mem (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire psrs_pkg::psrs_wr_type wr_i,
  input wire logic [psrs_pkg::DYN_AW-1:0] rd_addr_i,
  output logic [psrs_pkg::DATA_W-1:0] rd_data_o
);
  typedef struct packed {
    logic [psrs_pkg::DYN_DEPTH-1:0][psrs_pkg::DATA_W-1:0] mem;
    logic [psrs_pkg::DATA_W-1:0] rdata;
  } psrs_mem_type;

  psrs_mem_type cur;
  psrs_mem_type next_cur;

  always_comb
  begin
    next_cur = cur;
    if (wr_i.en)
    begin
      next_cur.mem[wr_i.addr] = wr_i.data;
    end
    next_cur.rdata = cur.mem[rd_addr_i];
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      cur <= '0;
    else
      cur <= next_cur;
  end

  assign rd_data_o = cur.rdata;
endmodule

/* File: design/psrs_clk_gen.sv */
// Purpose: Interface clock divider with run and drive control.
// Assumes: ref_clk_i divided by four, pclk high in phases 0 and 1.
// Notes: Stops low; the sample tick needs a rise first so a restart is clean.
`timescale 1ns/1ps
module psrs_clk_gen (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic run_i,
  input wire logic drive_i,
  output logic pclk_o,
  output logic pclk_oe_o,
  output psrs_pkg::psrs_tick_type tick_o
);
  typedef struct packed {
    logic [1:0] phase;
    logic pclk;
    logic oe;
    logic live;
  } psrs_cg_type;

  psrs_cg_type cur;
  psrs_cg_type next_cur;

  always_comb
  begin
    next_cur = cur;
    next_cur.oe = drive_i;
    if (run_i)
    begin
      next_cur.phase = cur.phase + 2'h1;
      next_cur.pclk = (next_cur.phase < psrs_pkg::PH_FALL);
      next_cur.live = cur.live | cur.pclk;
    end
    else
    begin
      next_cur.phase = psrs_pkg::PH_SAMPLE;
      next_cur.pclk = 1'h0;
      next_cur.live = 1'h0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cur.phase <= psrs_pkg::PH_SAMPLE;
      cur.pclk <= 1'h0;
      cur.oe <= 1'h0;
      cur.live <= 1'h0;
    end
    else
      cur <= next_cur;
  end

  assign pclk_o = cur.pclk;
  assign pclk_oe_o = cur.oe;
  assign tick_o.rise = run_i & cur.pclk & (cur.phase == psrs_pkg::PH_RISE);
  assign tick_o.sample = run_i & cur.live & (cur.phase == psrs_pkg::PH_SAMPLE);
endmodule

/* File: design/psrs_top.sv */
// Purpose: PHY operational states, interface clock control and register space.
// Assumes: Serial management frames are sent on the PHY-supplied interface clock.
// Notes: Frame is start bit, read flag, 8 address bits, one turnaround bit on reads, then 8 data bits, MSB first.
//
// Functional notes
// - Reset returns all configuration to defaults; it acts asynchronously.
// - Sleep keeps the radio off and leaves the interface clock undriven.
// - Standby keeps radio off, clock running unless clock stop is requested.
// - Ready powers part of the radio and keeps the clock running.
// - Transmit enables transmit paths and radio transmit, clock running.
// - Receive enables receive paths and radio receive, clock running.
// - Dynamic parameters live in registers reachable over the management line.
// - Static parameters never change for a given device instance.
// - 256 registers of 8 bits, 8-bit address and 8-bit data.
// - Addresses 00 to 1F hex are the dynamic register region.
// - Addresses 20 to 7F hex are an optional static parameter region.
// - Addresses 80 to FF hex belong to vendor registers.
// - Regulatory domain flags sit in bits 7 to 3; the rest reads zero.
// - Data rate flags per rate in bits 0, 2, 3, 5 to 9; rest zero.
// - Channel count is reported as one static byte.
// - All management line traffic is synchronous to the interface clock.
`timescale 1ns/1ps
module psrs_top #(
  parameter logic STATIC_IMPL = 1'h1,
  parameter logic [4:0] REGDOM_FLAGS = 5'h1f,
  parameter logic [15:0] DATA_RATE_FLAGS = 16'hffff,
  parameter logic [7:0] CHANNEL_COUNT = 8'h01
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic clock_stop_request_i,
  input wire logic wake_request_i,
  input wire logic serial_data_i,
  output logic serial_data_o,
  output logic serial_data_oe_o,
  output logic pclk_o,
  output logic pclk_oe_o,
  output logic radio_partial_on_o,
  output logic tx_path_en_o,
  output logic rx_path_en_o,
  output logic [2:0] phy_state_o
);
  typedef struct packed {
    logic [2:0] sync1;
    logic [2:0] sync2;
    psrs_pkg::psrs_state_type phy;
    logic [2:0] req;
    psrs_pkg::psrs_ser_type ser;
    logic [2:0] cnt;
    logic is_read;
    logic [7:0] addr;
    logic [7:0] shreg;
    logic sd_o;
    logic sd_oe;
    psrs_pkg::psrs_wr_type wr;
    logic radio;
    logic tx;
    logic rx;
    logic [2:0] code;
  } psrs_top_type;

  psrs_top_type cur;
  psrs_top_type next_cur;
  logic [1:0] rst_pipe;
  logic rst_n;
  logic run;
  logic drive;
  logic [7:0] mem_rdata;
  logic [7:0] rd_data;
  psrs_pkg::psrs_tick_type tick;

  function automatic psrs_pkg::psrs_region_type region_of(input logic [7:0] a);
    if (a <= psrs_pkg::DYN_LAST)
      return psrs_pkg::RG_DYN;
    else if (a <= psrs_pkg::STATIC_LAST)
      return psrs_pkg::RG_STATIC;
    else
      return psrs_pkg::RG_VENDOR;
  endfunction

  function automatic logic [2:0] state_code(input psrs_pkg::psrs_state_type s);
    case (s)
      psrs_pkg::PS_RESET: return psrs_pkg::CODE_RESET;
      psrs_pkg::PS_SLEEP: return psrs_pkg::CODE_SLEEP;
      psrs_pkg::PS_STANDBY: return psrs_pkg::CODE_STANDBY;
      psrs_pkg::PS_READY: return psrs_pkg::CODE_READY;
      psrs_pkg::PS_TX: return psrs_pkg::CODE_TX;
      psrs_pkg::PS_RX: return psrs_pkg::CODE_RX;
      default: return psrs_pkg::CODE_RESET;
    endcase
  endfunction

  function automatic logic [7:0] static_value(input logic [7:0] a);
    logic [15:0] rates;
    rates = DATA_RATE_FLAGS & psrs_pkg::RATE_VALID_MASK;
    if (!STATIC_IMPL)
      return psrs_pkg::READ_ZERO;
    case (a)
      psrs_pkg::ADDR_REGDOM_0: return {REGDOM_FLAGS, psrs_pkg::REGDOM_RSVD};
      psrs_pkg::ADDR_REGDOM_1: return psrs_pkg::REGDOM_HI_RSVD;
      psrs_pkg::ADDR_RATE_0: return rates[7:0];
      psrs_pkg::ADDR_RATE_1: return rates[15:8];
      psrs_pkg::ADDR_CHAN: return CHANNEL_COUNT;
      default: return psrs_pkg::READ_ZERO;
    endcase
  endfunction

  // Reset enters at once, leaves synchronised to the block clock
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rst_pipe <= 2'h0;
    else
      rst_pipe <= {rst_pipe[0], 1'h1};
  end
  assign rst_n = rst_pipe[1];

  // Clock stop only matters in standby; in other active states it is ignored
  assign run = (cur.phy != psrs_pkg::PS_RESET) && (cur.phy != psrs_pkg::PS_SLEEP) &&
    !((cur.phy == psrs_pkg::PS_STANDBY) && cur.sync2[psrs_pkg::SYNC_STOP]);
  assign drive = (cur.phy != psrs_pkg::PS_SLEEP);

  psrs_clk_gen u_clk_gen (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n),
    .run_i(run),
    .drive_i(drive),
    .pclk_o(pclk_o),
    .pclk_oe_o(pclk_oe_o),
    .tick_o(tick)
  );

  psrs_dyn_mem u_dyn_mem (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n),
    .wr_i(cur.wr),
    .rd_addr_i(cur.addr[psrs_pkg::DYN_AW-1:0]),
    .rd_data_o(mem_rdata)
  );

  // Read mux over the whole 256-byte space
  always_comb
  begin
    case (region_of(cur.addr))
      psrs_pkg::RG_DYN:
      begin
        if (cur.addr == psrs_pkg::ADDR_STATE_REQ)
          rd_data = {5'h00, cur.req};
        else if (cur.addr == psrs_pkg::ADDR_STATE_STAT)
          rd_data = {psrs_pkg::STAT_RSVD, cur.sync2[psrs_pkg::SYNC_STOP], cur.code};
        else
          rd_data = mem_rdata;
      end
      psrs_pkg::RG_STATIC: rd_data = static_value(cur.addr);
      default: rd_data = psrs_pkg::READ_ZERO;
    endcase
  end

  always_comb
  begin
    next_cur = cur;
    next_cur.sync1 = {serial_data_i, wake_request_i, clock_stop_request_i};
    next_cur.sync2 = cur.sync1;
    next_cur.wr.en = 1'h0;

    // Operational state sequencing
    case (cur.phy)
      psrs_pkg::PS_RESET: next_cur.phy = psrs_pkg::PS_STANDBY;
      psrs_pkg::PS_SLEEP:
      begin
        // No interface clock here, so a pin is the only way back out
        if (cur.sync2[psrs_pkg::SYNC_WAKE])
        begin
          next_cur.phy = psrs_pkg::PS_STANDBY;
          next_cur.req = psrs_pkg::CODE_STANDBY;
        end
      end
      default:
      begin
        case (cur.req)
          psrs_pkg::CODE_SLEEP: next_cur.phy = psrs_pkg::PS_SLEEP;
          psrs_pkg::CODE_STANDBY: next_cur.phy = psrs_pkg::PS_STANDBY;
          psrs_pkg::CODE_READY: next_cur.phy = psrs_pkg::PS_READY;
          psrs_pkg::CODE_TX: next_cur.phy = psrs_pkg::PS_TX;
          psrs_pkg::CODE_RX: next_cur.phy = psrs_pkg::PS_RX;
          default: next_cur.phy = cur.phy;
        endcase
      end
    endcase

    // Management frame; every step waits on an interface clock tick
    case (cur.ser)
      psrs_pkg::SM_IDLE:
      begin
        if (tick.sample && cur.sync2[psrs_pkg::SYNC_SD])
          next_cur.ser = psrs_pkg::SM_RW;
      end
      psrs_pkg::SM_RW:
      begin
        if (tick.sample)
        begin
          next_cur.is_read = cur.sync2[psrs_pkg::SYNC_SD];
          next_cur.cnt = psrs_pkg::BIT_LAST;
          next_cur.ser = psrs_pkg::SM_ADDR;
        end
      end
      psrs_pkg::SM_ADDR:
      begin
        if (tick.sample)
        begin
          next_cur.addr = {cur.addr[6:0], cur.sync2[psrs_pkg::SYNC_SD]};
          next_cur.cnt = cur.cnt - 3'h1;
          if (cur.cnt == 3'h0)
          begin
            next_cur.cnt = psrs_pkg::BIT_LAST;
            next_cur.ser = cur.is_read ? psrs_pkg::SM_TURN : psrs_pkg::SM_WDATA;
          end
        end
      end
      psrs_pkg::SM_WDATA:
      begin
        if (tick.sample)
        begin
          next_cur.shreg = {cur.shreg[6:0], cur.sync2[psrs_pkg::SYNC_SD]};
          next_cur.cnt = cur.cnt - 3'h1;
          if (cur.cnt == 3'h0)
          begin
            next_cur.ser = psrs_pkg::SM_IDLE;
            // Static and vendor writes are dropped on purpose
            if (cur.addr == psrs_pkg::ADDR_STATE_REQ)
              next_cur.req = next_cur.shreg[2:0];
            else if (region_of(cur.addr) == psrs_pkg::RG_DYN &&
              cur.addr != psrs_pkg::ADDR_STATE_STAT)
            begin
              next_cur.wr.en = 1'h1;
              next_cur.wr.addr = cur.addr[psrs_pkg::DYN_AW-1:0];
              next_cur.wr.data = next_cur.shreg;
            end
          end
        end
      end
      psrs_pkg::SM_TURN:
      begin
        // One idle bit lets the MAC release the line and the read data settle
        if (tick.sample)
          next_cur.ser = psrs_pkg::SM_RDATA;
      end
      psrs_pkg::SM_RDATA:
      begin
        if (tick.rise)
        begin
          if (!cur.sd_oe)
          begin
            next_cur.sd_oe = 1'h1;
            next_cur.sd_o = rd_data[7];
            next_cur.shreg = {rd_data[6:0], 1'h0};
            next_cur.cnt = psrs_pkg::BIT_LAST;
          end
          else if (cur.cnt == 3'h0)
          begin
            next_cur.sd_oe = 1'h0;
            next_cur.sd_o = 1'h0;
            next_cur.ser = psrs_pkg::SM_IDLE;
          end
          else
          begin
            next_cur.sd_o = cur.shreg[7];
            next_cur.shreg = {cur.shreg[6:0], 1'h0};
            next_cur.cnt = cur.cnt - 3'h1;
          end
        end
      end
      default: next_cur.ser = psrs_pkg::SM_IDLE;
    endcase

    // A frame cut off by sleep would never finish; drop it and free the line
    if (next_cur.phy == psrs_pkg::PS_SLEEP)
    begin
      next_cur.ser = psrs_pkg::SM_IDLE;
      next_cur.sd_oe = 1'h0;
      next_cur.sd_o = 1'h0;
    end

    next_cur.radio = (next_cur.phy == psrs_pkg::PS_READY) ||
      (next_cur.phy == psrs_pkg::PS_TX) || (next_cur.phy == psrs_pkg::PS_RX);
    next_cur.tx = (next_cur.phy == psrs_pkg::PS_TX);
    next_cur.rx = (next_cur.phy == psrs_pkg::PS_RX);
    next_cur.code = state_code(next_cur.phy);
  end

  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cur <= '0;
      cur.phy <= psrs_pkg::PS_RESET;
      cur.req <= psrs_pkg::CODE_STANDBY;
      cur.ser <= psrs_pkg::SM_IDLE;
      cur.code <= psrs_pkg::CODE_RESET;
    end
    else
      cur <= next_cur;
  end

  assign serial_data_o = cur.sd_o;
  assign serial_data_oe_o = cur.sd_oe;
  assign radio_partial_on_o = cur.radio;
  assign tx_path_en_o = cur.tx;
  assign rx_path_en_o = cur.rx;
  assign phy_state_o = cur.code;
endmodule

/* File: test/psrs_properties.sv */
// Purpose: Port-level properties of the PHY state and register space block.
// Assumes: State codes as on phy_state_o; outputs registered.
// Notes: Reset hold ignores the default disable, since reset is its cause.
`timescale 1ns/1ps
module psrs_properties (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic clock_stop_request_i,
  input wire logic serial_data_o,
  input wire logic serial_data_oe_o,
  input wire logic pclk_o,
  input wire logic pclk_oe_o,
  input wire logic radio_partial_on_o,
  input wire logic tx_path_en_o,
  input wire logic rx_path_en_o,
  input wire logic [2:0] phy_state_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  AST_RESET_HOLD: assert property (disable iff (1'b0) !rst_n_i |->
    phy_state_o == 3'h0 && !pclk_oe_o && !serial_data_oe_o) else $error("active in reset");
  AST_RESET_EXIT: assert property ($rose(rst_n_i) |-> ##[1:5] phy_state_o == 3'h2)
    else $error("no standby after reset");
  AST_SLEEP: assert property ($stable(phy_state_o) && phy_state_o == 3'h1 |->
    !pclk_oe_o && !radio_partial_on_o && !tx_path_en_o && !rx_path_en_o)
    else $error("sleep drives clock or radio");
  AST_STANDBY_RUN: assert property ((phy_state_o == 3'h2 && !clock_stop_request_i) [*8]
    |-> ##[0:3] $changed(pclk_o)) else $error("standby clock idle");
  AST_STANDBY_STOP: assert property ((phy_state_o == 3'h2 && clock_stop_request_i) [*8]
    |-> ##2 !pclk_o && pclk_oe_o) else $error("stopped clock not low");
  AST_READY: assert property (phy_state_o == 3'h3 |->
    radio_partial_on_o && !tx_path_en_o && !rx_path_en_o) else $error("ready pins");
  AST_TX: assert property (phy_state_o == 3'h4 |->
    radio_partial_on_o && tx_path_en_o && !rx_path_en_o) else $error("transmit pins");
  AST_RX: assert property (phy_state_o == 3'h5 |->
    radio_partial_on_o && rx_path_en_o && !tx_path_en_o) else $error("receive pins");
  AST_CLK_ON: assert property (phy_state_o inside {3'h3, 3'h4, 3'h5} |->
    pclk_oe_o ##0 (##[0:2] $changed(pclk_o))) else $error("clock not running");
  AST_SERIAL_SYNC: assert property ($changed(serial_data_o) && serial_data_oe_o &&
    $past(serial_data_oe_o) |-> pclk_o) else $error("read bit off clock phase");
endmodule
bind psrs_top psrs_properties u_props (
  .ref_clk_i(ref_clk_i),
  .rst_n_i(rst_n_i),
  .clock_stop_request_i(clock_stop_request_i),
  .serial_data_o(serial_data_o),
  .serial_data_oe_o(serial_data_oe_o),
  .pclk_o(pclk_o),
  .pclk_oe_o(pclk_oe_o),
  .radio_partial_on_o(radio_partial_on_o),
  .tx_path_en_o(tx_path_en_o),
  .rx_path_en_o(rx_path_en_o),
  .phy_state_o(phy_state_o)
);

/* File: test/psrs_mac_model.sv */
// Purpose: Controller side of the serial management line.
// Assumes: Bits change just after a pclk rise; a pclk period is 40 ns.
// Notes: A released line shows the inverse of the last driven bit.
`timescale 1ns/1ps
module psrs_mac_model (
  input wire logic pclk_i,
  input wire logic dev_data_i,
  input wire logic dev_oe_i,
  output logic line_o
);
  logic drv = 1'b1;
  logic bit_v = 1'b0;
  logic last = 1'b0;
  assign line_o = dev_oe_i ? dev_data_i : (drv ? bit_v : ~last);
  task automatic put(input logic b);
    @(posedge pclk_i);
    #1;
    drv = 1'b1;
    bit_v = b;
    last = b;
  endtask
  task automatic frame(input logic rd_i, input logic [7:0] a, input logic [7:0] d,
    output logic [7:0] q);
    q = 8'h00;
    put(1'b1);
    put(rd_i);
    for (int i = 7; i >= 0; i--)
      put(a[i]);
    if (rd_i)
    begin
      @(posedge pclk_i);
      #1;
      drv = 1'b0;
      @(posedge pclk_i);
      for (int i = 7; i >= 0; i--)
      begin
        @(posedge pclk_i);
        q[i] = line_o;
      end
      // Take the idle low back only once the device lets go
      wait (!dev_oe_i);
      #1;
      drv = 1'b1;
      bit_v = 1'b0;
      last = 1'b0;
    end
    else
    begin
      for (int i = 7; i >= 0; i--)
        put(d[i]);
      #40;
      bit_v = 1'b0;
      last = 1'b0;
    end
  endtask
endmodule

/* File: test/testbench.sv */
// Purpose: Self-checking bench for the PHY state and register space block.
// Assumes: Default top parameters; controller model runs the line.
// Notes: A frame takes about 90 ref cycles; the watchdog allows far more.
`timescale 1ns/1ps
module testbench;
  logic ref_clk_i;
  logic rst_n_i;
  logic stop;
  logic wake;
  logic line;
  logic sd_o;
  logic sd_oe;
  logic pclk;
  logic pclk_oe;
  logic pclk_w;
  logic radio;
  logic tx;
  logic rx;
  logic a;
  logic [2:0] st;
  int n_errors = 0;
  int comparisons = 0;
  assign pclk_w = pclk_oe ? pclk : 1'b1;
  psrs_top dut (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .clock_stop_request_i(stop),
    .wake_request_i(wake),
    .serial_data_i(line),
    .serial_data_o(sd_o),
    .serial_data_oe_o(sd_oe),
    .pclk_o(pclk),
    .pclk_oe_o(pclk_oe),
    .radio_partial_on_o(radio),
    .tx_path_en_o(tx),
    .rx_path_en_o(rx),
    .phy_state_o(st)
  );
  psrs_mac_model mac (.pclk_i(pclk_w), .dev_data_i(sd_o), .dev_oe_i(sd_oe), .line_o(line));
  initial
  begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    logic [7:0] q;
    mac.frame(1'b0, ad, d, q);
  endtask
  task automatic rd(input logic [7:0] ad, input logic [7:0] exp);
    logic [7:0] q;
    mac.frame(1'b1, ad, 8'h00, q);
    chk($sformatf("reg %h", ad), exp, q);
  endtask
  task automatic pins(input logic [2:0] s, input logic [2:0] rtr);
    chk("state", {5'h00, s}, {5'h00, st});
    chk("radio pins", {5'h00, rtr}, {5'h00, radio, tx, rx});
  endtask
  task automatic t_states;
    logic [2:0] code [4] = '{3'h3, 3'h4, 3'h5, 3'h2};
    logic [2:0] rtr [4] = '{3'h4, 3'h6, 3'h5, 3'h0};
    pins(3'h2, 3'h0);
    rd(8'h00, 8'h02);
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h00, {5'h00, code[i]});
      cyc(2);
      pins(code[i], rtr[i]);
    end
    wr(8'h00, 8'h07);
    cyc(2);
    pins(3'h2, 3'h0);
    rd(8'h00, 8'h07);
    $display("END t_states");
  endtask
  task automatic t_space;
    wr(8'h1f, 8'ha5);
    wr(8'h02, 8'h5a);
    wr(8'h01, 8'hff);
    wr(8'h22, 8'h00);
    wr(8'h24, 8'hff);
    wr(8'h80, 8'h3c);
    rd(8'h1f, 8'ha5);
    rd(8'h02, 8'h5a);
    rd(8'h01, 8'h02);
    rd(8'h20, 8'hf8);
    rd(8'h21, 8'h00);
    rd(8'h22, 8'hed);
    rd(8'h23, 8'h03);
    rd(8'h24, 8'h01);
    rd(8'h7f, 8'h00);
    rd(8'h80, 8'h00);
    rd(8'hff, 8'h00);
    $display("END t_space");
  endtask
  task automatic t_clock;
    stop = 1'b1;
    cyc(12);
    chk("stopped clock", 8'h00, {7'h00, pclk});
    cyc(3);
    chk("stopped clock", 8'h00, {7'h00, pclk});
    stop = 1'b0;
    cyc(10);
    a = pclk;
    cyc(2);
    chk("running clock", {7'h00, ~a}, {7'h00, pclk});
    wr(8'h00, 8'h01);
    cyc(4);
    pins(3'h1, 3'h0);
    chk("clock drive", 8'h00, {7'h00, pclk_oe});
    wake = 1'b1;
    cyc(6);
    wake = 1'b0;
    pins(3'h2, 3'h0);
    cyc(8);
    rd(8'h00, 8'h02);
    $display("END t_clock");
  endtask
  task automatic t_midreset;
    wr(8'h05, 8'h99);
    rd(8'h05, 8'h99);
    rst_n_i = 1'b0;
    cyc(3);
    chk("state in reset", 8'h00, {5'h00, st});
    rst_n_i = 1'b1;
    cyc(10);
    rd(8'h05, 8'h00);
    $display("END t_midreset");
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    rst_n_i = 1'b1;
    stop = 1'b0;
    wake = 1'b0;
    #1;
    rst_n_i = 1'b0;
    cyc(5);
    rst_n_i = 1'b1;
    cyc(10);
    t_states;
    t_space;
    t_clock;
    t_midreset;
    results;
  end
  // About 30 frames at 1 us each; over ten times that is a hang
  initial
  begin
    #400000;
    n_errors++;
    results;
  end
endmodule
